//--- shared/pcrc_regs.svh
// pcrc register offsets, field positions and constants
`ifndef PCRC_REGS_SVH
`define PCRC_REGS_SVH

// register word offsets on the register port
`define PCRC_A_CON1   4'h0
`define PCRC_A_CON2   4'h1
`define PCRC_A_XORL   4'h2
`define PCRC_A_XORH   4'h3
`define PCRC_A_DATL   4'h4
`define PCRC_A_DATH   4'h5
`define PCRC_A_WDATL  4'h6
`define PCRC_A_WDATH  4'h7

// crc_control_one fields
`define PCRC_B_EN     15
`define PCRC_B_SIDL   13
`define PCRC_B_CNT_HI 12
`define PCRC_B_CNT_LO 8
`define PCRC_B_FUL    7
`define PCRC_B_MPT    6
`define PCRC_B_ISEL   5
`define PCRC_B_GO     4
`define PCRC_B_LEND   3

// crc_control_two fields
`define PCRC_B_DW_HI  12
`define PCRC_B_DW_LO  8
`define PCRC_B_PL_HI  4
`define PCRC_B_PL_LO  0

// fifo depths and width thresholds (width setting = bits - 1)
`define PCRC_DEPTH_S  5'h04
`define PCRC_DEPTH_M  5'h08
`define PCRC_DEPTH_L  5'h10
`define PCRC_DW_BIG   5'h10
`define PCRC_DW_MID   5'h08
`define PCRC_DW_HALF  5'h10

// engine constants
`define PCRC_TOP      5'h1f
`define PCRC_ONES     32'hffffffff
`define PCRC_X0       32'h00000001
`define PCRC_X0_CLR   32'hfffffffe
`define PCRC_ONE6     6'h01
`define PCRC_STEP     6'h02
`define PCRC_CNT_ONE  5'h01
`define PCRC_W32_CYC  5'h10

`endif

//--- shared/pcrc_pkg.sv
// pcrc shared types
package pcrc_pkg;

	// one register port request
	typedef struct packed {
		logic [3:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} pcrc_req_s;

	// shift engine state
	typedef enum logic {
		ENG_IDLE  = 1'b0,
		ENG_SHIFT = 1'b1
	} pcrc_eng_e;

endpackage

//--- hw/pcrc_top.sv
// pcrc_top: programmable crc generator with input fifo and register port
`include "pcrc_regs.svh"
//==============================================================
module pcrc_top (
	input  wire logic              core_clk,
	input  wire logic              sys_rst,
	input  wire pcrc_pkg::pcrc_req_s bus_req,
	input  wire logic              cpu_idle,
	output logic [15:0]            rd_data_q,
	output logic                   crc_irq_q
);

	//==============================================================
	// helpers

	// ones in bits top..0
	function automatic logic [31:0] lsb_mask(input logic [4:0] top);
		lsb_mask = `PCRC_ONES >> (`PCRC_TOP - top);
	endfunction

	// fifo depth for a width setting
	function automatic logic [4:0] fifo_depth(input logic [4:0] dw);
		if (dw >= `PCRC_DW_BIG) begin
			fifo_depth = `PCRC_DEPTH_S;
		end else if (dw >= `PCRC_DW_MID) begin
			fifo_depth = `PCRC_DEPTH_M;
		end else begin
			fifo_depth = `PCRC_DEPTH_L;
		end
	endfunction

	// write strobe aimed at one register
	function automatic logic wr_hit(input pcrc_pkg::pcrc_req_s r, input logic [3:0] a);
		wr_hit = r.wr && (r.addr == a);
	endfunction

	// one serial lfsr step, top bit index n
	function automatic logic [31:0] crc_step(
		input logic [31:0] c,
		input logic        d,
		input logic [31:0] p,
		input logic [4:0]  n
	);
		logic fb;
		fb = d ^ c[n];
		crc_step = ((c << 1) ^ ({32{fb}} & (p | `PCRC_X0))) & lsb_mask(n);
	endfunction

	// move the shift buffer by one bit
	function automatic logic [31:0] buf_shift(input logic [31:0] b, input logic lend);
		buf_shift = lend ? (b >> 1) : (b << 1);
	endfunction

	// bit presented to the engine
	function automatic logic buf_bit(input logic [31:0] b, input logic lend);
		buf_bit = lend ? b[0] : b[31];
	endfunction

	//==============================================================
	// state

	logic                en_q, en_d, sidl_q, sidl_d;
	logic                isel_q, isel_d, go_q, go_d, lend_q, lend_d;
	logic [4:0]          dw_q, dw_d, pl_q, pl_d;
	logic [31:0]         poly_q, poly_d;
	logic [15:0]         datl_q, datl_d, dath_q, dath_d;
	logic [31:0]         mem [16];
	logic [3:0]          wp_q, wp_d, rp_q, rp_d;
	logic [4:0]          cnt_q, cnt_d;
	pcrc_pkg::pcrc_eng_e eng_q, eng_d;
	logic [31:0]         sbuf_q, sbuf_d, res_q, res_d;
	logic [5:0]          left_q, left_d;
	logic [4:0]          wrun_q, wrun_d;
	logic                wide_q, wide_d;
	logic                irq_d;
	logic [15:0]         rdata_d;

	logic                wr_c1, run, full, empty;
	logic                push_lo, push_hi, push_req, push, pop, hw_done;
	logic [31:0]         push_word, s1, s2, c1, c2;

	//==============================================================
	// decode and fifo status

	assign wr_c1     = wr_hit(bus_req, `PCRC_A_CON1);
	assign run       = en_q && !(sidl_q && cpu_idle);
	assign full      = (cnt_q == fifo_depth(dw_q));
	assign empty     = (cnt_q == '0);
	assign push_lo   = wr_hit(bus_req, `PCRC_A_DATL) && (dw_q < `PCRC_DW_HALF);
	assign push_hi   = wr_hit(bus_req, `PCRC_A_DATH) && (dw_q >= `PCRC_DW_HALF);
	assign push_req  = en_q && (push_lo || push_hi);
	assign push      = push_req && !full;
	assign pop       = run && go_q && (eng_q == pcrc_pkg::ENG_IDLE) && !empty;
	assign hw_done   = run && go_q && (eng_q == pcrc_pkg::ENG_IDLE) && empty;
	assign push_word = (push_hi ? {bus_req.wdata, datl_q} : {16'h0000, bus_req.wdata})
		& lsb_mask(dw_q);

	//==============================================================
	// control and configuration registers

	// next control values; software write wins over the hardware clear
	always_comb begin
		en_d   = en_q;
		sidl_d = sidl_q;
		isel_d = isel_q;
		go_d   = go_q;
		lend_d = lend_q;
		dw_d   = dw_q;
		pl_d   = pl_q;
		poly_d = poly_q;
		if (wr_c1) begin
			en_d   = bus_req.wdata[`PCRC_B_EN];
			sidl_d = bus_req.wdata[`PCRC_B_SIDL];
			isel_d = bus_req.wdata[`PCRC_B_ISEL];
			go_d   = bus_req.wdata[`PCRC_B_GO];
			lend_d = bus_req.wdata[`PCRC_B_LEND];
		end else if (hw_done) begin
			go_d = 1'b0;
		end
		if (wr_hit(bus_req, `PCRC_A_CON2)) begin
			dw_d = bus_req.wdata[`PCRC_B_DW_HI:`PCRC_B_DW_LO];
			pl_d = bus_req.wdata[`PCRC_B_PL_HI:`PCRC_B_PL_LO];
		end
		if (wr_hit(bus_req, `PCRC_A_XORL)) begin
			poly_d[15:0] = 16'(bus_req.wdata & `PCRC_X0_CLR);
		end
		if (wr_hit(bus_req, `PCRC_A_XORH)) begin
			poly_d[31:16] = bus_req.wdata;
		end
	end

	// control registers keep their value while disabled
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			en_q   <= 1'b0;
			sidl_q <= 1'b0;
			isel_q <= 1'b0;
			go_q   <= 1'b0;
			lend_q <= 1'b0;
			dw_q   <= '0;
			pl_q   <= '0;
			poly_q <= '0;
		end else begin
			en_q   <= en_d;
			sidl_q <= sidl_d;
			isel_q <= isel_d;
			go_q   <= go_d;
			lend_q <= lend_d;
			dw_q   <= dw_d;
			pl_q   <= pl_d;
			poly_q <= poly_d;
		end
	end

	//==============================================================
	// input data registers and fifo

	// pointers and count; disable empties the fifo
	always_comb begin
		datl_d = datl_q;
		dath_d = dath_q;
		wp_d   = wp_q;
		rp_d   = rp_q;
		cnt_d  = cnt_q;
		if (!en_q) begin
			datl_d = '0;
			dath_d = '0;
			wp_d   = '0;
			rp_d   = '0;
			cnt_d  = '0;
		end else begin
			if (wr_hit(bus_req, `PCRC_A_DATL)) begin
				datl_d = bus_req.wdata;
			end
			if (wr_hit(bus_req, `PCRC_A_DATH)) begin
				dath_d = bus_req.wdata;
			end
			if (push) begin
				wp_d = wp_q + 4'h1;
			end
			if (pop) begin
				rp_d = rp_q + 4'h1;
			end
			cnt_d = cnt_q + {4'h0, push} - {4'h0, pop};
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			datl_q <= '0;
			dath_q <= '0;
			wp_q   <= '0;
			rp_q   <= '0;
			cnt_q  <= '0;
		end else begin
			datl_q <= datl_d;
			dath_q <= dath_d;
			wp_q   <= wp_d;
			rp_q   <= rp_d;
			cnt_q  <= cnt_d;
		end
	end

	// word storage, no reset needed
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wp_q] <= push_word;
		end
	end

	//==============================================================
	// shift engine and result

	// two bits per cycle; a last odd bit takes a single step
	assign s1 = buf_shift(sbuf_q, lend_q);
	assign s2 = buf_shift(s1, lend_q);
	assign c1 = crc_step(res_q, buf_bit(sbuf_q, lend_q), poly_q, pl_q);
	assign c2 = crc_step(c1, buf_bit(s1, lend_q), poly_q, pl_q);

	always_comb begin
		eng_d  = eng_q;
		sbuf_d = sbuf_q;
		left_d = left_q;
		res_d  = res_q;
		irq_d  = 1'b0;
		// run cycles spent on the current word, kept for the timing check
		wide_d = wide_q;
		wrun_d = wrun_q;
		if (!en_q) begin
			eng_d  = pcrc_pkg::ENG_IDLE;
			sbuf_d = '0;
			left_d = '0;
			res_d  = '0;
		end else begin
			if (wr_hit(bus_req, `PCRC_A_WDATL)) begin
				res_d[15:0] = bus_req.wdata;
			end
			if (wr_hit(bus_req, `PCRC_A_WDATH)) begin
				res_d[31:16] = bus_req.wdata;
			end
			unique case (eng_q)
				pcrc_pkg::ENG_IDLE: begin
					if (pop) begin
						// msb-first: align so the word's msb sits at bit 31; lsb-first words stay at bit 0
						sbuf_d = lend_q ? mem[rp_q] : (mem[rp_q] << (`PCRC_TOP - dw_q));
						left_d = {1'b0, dw_q} + `PCRC_ONE6;
						eng_d  = pcrc_pkg::ENG_SHIFT;
						wide_d = (dw_q == `PCRC_TOP);
						wrun_d = '0;
					end
				end
				pcrc_pkg::ENG_SHIFT: begin
					if (run) begin
						wrun_d = wrun_q + `PCRC_CNT_ONE;
						if (left_q >= `PCRC_STEP) begin
							res_d  = c2;
							sbuf_d = s2;
							left_d = left_q - `PCRC_STEP;
						end else begin
							res_d  = c1;
							sbuf_d = s1;
							left_d = '0;
						end
						if (left_q <= `PCRC_STEP) begin
							eng_d = pcrc_pkg::ENG_IDLE;
						end
					end
				end
			endcase
			// interrupt source chosen by select bit
			irq_d = (!isel_q && pop && !push && (cnt_q == `PCRC_CNT_ONE))
				|| (isel_q && hw_done && !wr_c1);
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			eng_q     <= pcrc_pkg::ENG_IDLE;
			sbuf_q    <= '0;
			left_q    <= '0;
			res_q     <= '0;
			crc_irq_q <= 1'b0;
			wide_q    <= 1'b0;
			wrun_q    <= '0;
		end else begin
			eng_q     <= eng_d;
			sbuf_q    <= sbuf_d;
			left_q    <= left_d;
			res_q     <= res_d;
			crc_irq_q <= irq_d;
			wide_q    <= wide_d;
			wrun_q    <= wrun_d;
		end
	end

	//==============================================================
	// register readback, data one cycle after the read strobe

	always_comb begin
		rdata_d = '0;
		if (bus_req.rd) begin
			unique case (bus_req.addr)
				`PCRC_A_CON1: begin
					rdata_d[`PCRC_B_EN]                   = en_q;
					rdata_d[`PCRC_B_SIDL]                 = sidl_q;
					rdata_d[`PCRC_B_CNT_HI:`PCRC_B_CNT_LO] = cnt_q;
					rdata_d[`PCRC_B_FUL]                  = full;
					rdata_d[`PCRC_B_MPT]                  = empty;
					rdata_d[`PCRC_B_ISEL]                 = isel_q;
					rdata_d[`PCRC_B_GO]                   = go_q;
					rdata_d[`PCRC_B_LEND]                 = lend_q;
				end
				`PCRC_A_CON2: begin
					rdata_d[`PCRC_B_DW_HI:`PCRC_B_DW_LO] = dw_q;
					rdata_d[`PCRC_B_PL_HI:`PCRC_B_PL_LO] = pl_q;
				end
				`PCRC_A_XORL:  rdata_d = poly_q[15:0];
				`PCRC_A_XORH:  rdata_d = poly_q[31:16];
				`PCRC_A_DATL:  rdata_d = datl_q;
				`PCRC_A_DATH:  rdata_d = dath_q;
				`PCRC_A_WDATL: rdata_d = res_q[15:0];
				`PCRC_A_WDATH: rdata_d = res_q[31:16];
				default:       rdata_d = '0; // unmapped reads zero
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rd_data_q <= '0;
		end else begin
			rd_data_q <= rdata_d;
		end
	end

	//==============================================================
	// checks

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	a_count_bound: assert property (cnt_q <= fifo_depth(dw_q))
		else $error("word count above fifo depth");
	a_full_drop: assert property (push_req && full && !pop |=> $stable(cnt_q))
		else $error("write into full fifo changed count");
	a_disable_clear: assert property (!en_q |=> cnt_q == '0 && res_q == '0
		&& eng_q == pcrc_pkg::ENG_IDLE)
		else $error("disable did not clear fifo and engine");
	a_pop_count: assert property (pop && !push |=> cnt_q == $past(cnt_q) - `PCRC_CNT_ONE)
		else $error("pop did not decrement count");
	a_word_time: assert property (
		wide_q && eng_q == pcrc_pkg::ENG_SHIFT && run
		|=> (eng_q == pcrc_pkg::ENG_IDLE) == (wrun_q == `PCRC_W32_CYC))
		else $error("32-bit word not done in 16 cycles");
	a_done_irq: assert property (hw_done && isel_q && !wr_c1 |=> crc_irq_q && !go_q)
		else $error("completion did not clear start and interrupt");
	a_sw_stop: assert property (wr_c1 && isel_q && !bus_req.wdata[`PCRC_B_GO] |=> !crc_irq_q)
		else $error("software stop raised an interrupt");
	a_empty_irq: assert property (
		!isel_q && pop && !push && cnt_q == `PCRC_CNT_ONE |=> crc_irq_q && cnt_q == '0)
		else $error("count 1 to 0 gave no interrupt");
	a_idle_hold: assert property (en_q && sidl_q && cpu_idle && eng_q == pcrc_pkg::ENG_SHIFT
		&& !wr_hit(bus_req, `PCRC_A_WDATL) && !wr_hit(bus_req, `PCRC_A_WDATH) |=> $stable(res_q))
		else $error("engine moved while stopped in idle");

	c_word_load: cover property (pop);
	c_calc_done: cover property (hw_done && isel_q);
	c_fifo_full: cover property (full && en_q);
	c_idle_hold: cover property (en_q && sidl_q && cpu_idle && eng_q == pcrc_pkg::ENG_SHIFT);

endmodule

//--- sim/pcrc_top_tb.sv
// self-checking random testbench for the programmable crc generator
`include "pcrc_regs.svh"
module pcrc_top_tb;
	timeunit 1ns;
	timeprecision 1ns;

	//==============================================================
	// clock, reset, stimulus signals
	logic                 core_clk;
	logic                 sys_rst;
	logic                 cpu_idle;
	pcrc_pkg::pcrc_req_s  req;
	logic [15:0]          rd_data_q;
	logic                 crc_irq_q;
	int                   fail_count;
	int                   compares;
	int                   irq_cnt;
	int                   cyc;
	int                   seed;

	pcrc_top i_dut (
		.core_clk  (core_clk),
		.sys_rst   (sys_rst),
		.bus_req   (req),
		.cpu_idle  (cpu_idle),
		.rd_data_q (rd_data_q),
		.crc_irq_q (crc_irq_q)
	);

	// 20 mhz clock
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	// count interrupt pulses and cut a hang short
	always @(posedge core_clk) begin
		if (crc_irq_q === 1'b1) irq_cnt <= irq_cnt + 1;
		cyc <= cyc + 1;
		if (cyc == 50000) begin
			fail_count++;
			conclude();
		end
	end

	//==============================================================
	// bus tasks and comparison
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge core_clk);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk);
		req.wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge core_clk);
		req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge core_clk);
		req.rd <= 1'b0;
		#1 d = rd_data_q;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic rchk(input logic [3:0] a, input logic [15:0] exp);
		logic [15:0] d;
		rd(a, d);
		chk({16'h0000, d}, {16'h0000, exp});
	endtask

	// waits for the next interrupt pulse, returns cycles waited
	task automatic wait_irq(output int n);
		int base;
		base = irq_cnt;
		n = 0;
		while (irq_cnt == base && n < 400) begin
			@(posedge core_clk);
			n++;
		end
		chk(n < 400, 1'b1);
	endtask

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	//==============================================================
	// reference model
	function automatic int depth(input int dw);
		if (dw > 15) return 4;
		if (dw >= 8) return 8;
		return 16;
	endfunction

	function automatic logic [31:0] step(input logic [31:0] c, input logic [31:0] w,
		input int wb, input int n, input logic [31:0] p, input logic lend);
		logic [31:0] m;
		logic        fb;
		m = (n == 32) ? 32'hffffffff : ((32'h00000001 << n) - 32'h00000001);
		for (int k = 0; k < wb; k++) begin
			fb = (lend ? w[k] : w[wb-1-k]) ^ c[n-1];
			c = ((c << 1) ^ (fb ? (p | 32'h00000001) : 32'h00000000)) & m;
		end
		return c;
	endfunction

	//==============================================================
	// main sequence
	initial begin
		logic [15:0] v, lo, hi;
		logic [31:0] p, raw, crc, msk;
		logic        lend, isel;
		int          poly_length_field, dw, dep, nw, pushed, n;
		seed = 79697;
		fail_count = 0;
		compares = 0;
		irq_cnt = 0;
		cyc = 0;
		sys_rst = 1'b1;
		cpu_idle = 1'b0;
		req = '{addr: 4'h0, wdata: 16'h0000, wr: 1'b0, rd: 1'b0};
		repeat (16) @(posedge core_clk);
		sys_rst <= 1'b0;
		rchk(`PCRC_A_CON1, 16'h0040);
		rchk(`PCRC_A_CON2, 16'h0000);
		rchk(`PCRC_A_WDATH, 16'h0000);
		wr(4'h9, 16'hffff);
		rchk(4'h9, 16'h0000);
		for (int i = 0; i < 14; i++) begin
			poly_length_field = $unsigned($random(seed)) % 32;
			dw = $unsigned($random(seed)) % 32;
			lend = 1'($random(seed));
			isel = 1'($random(seed));
			if (i == 0) begin
				poly_length_field = 31;
				dw = 31;
				lend = 1'b0;
				isel = 1'b1;
			end
			if (i == 1) begin
				poly_length_field = 0;
				dw = 0;
				isel = 1'b0;
			end
			p = $random(seed);
			dep = depth(dw);
			nw = (i == 0) ? 1 : 1 + ($unsigned($random(seed)) % (dep + 1));
			pushed = (nw > dep) ? dep : nw;
			msk = (dw == 31) ? 32'hffffffff : ((32'h00000001 << (dw + 1)) - 32'h00000001);
			v = 16'h8000 | (16'(isel) << 5) | (16'(lend) << 3);
			wr(`PCRC_A_CON1, v);
			wr(`PCRC_A_CON2, {3'h0, 5'(dw), 3'h0, 5'(poly_length_field)});
			wr(`PCRC_A_XORL, p[15:0]);
			wr(`PCRC_A_XORH, p[31:16]);
			rchk(`PCRC_A_XORL, p[15:0] & 16'hfffe);
			wr(`PCRC_A_WDATL, 16'h0000);
			wr(`PCRC_A_WDATH, 16'h0000);
			crc = 32'h00000000;
			for (int j = 0; j < nw; j++) begin
				raw = $random(seed);
				wr(`PCRC_A_DATL, raw[15:0]);
				if (dw >= 16) wr(`PCRC_A_DATH, raw[31:16]);
				if (j < dep) crc = step(crc, raw & msk, dw + 1, poly_length_field + 1, p, lend);
			end
			// count, full and empty after the fill, overflow words dropped
			rchk(`PCRC_A_CON1, v | (16'(pushed) << 8) | (16'(pushed == dep) << 7));
			cpu_idle <= 1'($random(seed));
			wr(`PCRC_A_CON1, v | 16'h0010);
			wait_irq(n);
			if (i == 0) chk(n >= 16 && n <= 22, 1'b1);
			for (int k = 0; k < 40; k++) begin
				rd(`PCRC_A_CON1, lo);
				if (lo[4] === 1'b0) break;
			end
			chk({16'h0000, lo}, {16'h0000, v | 16'h0040});
			cpu_idle <= 1'b0;
			rd(`PCRC_A_WDATL, lo);
			rd(`PCRC_A_WDATH, hi);
			chk({hi, lo}, crc);
		end
		// disable empties fifo and result, keeps configuration
		wr(`PCRC_A_CON1, 16'h8028);
		wr(`PCRC_A_CON2, 16'h0707);
		wr(`PCRC_A_DATL, 16'h00a5);
		wr(`PCRC_A_DATL, 16'h005a);
		wr(`PCRC_A_WDATL, 16'h1234);
		rchk(`PCRC_A_CON1, 16'h8228);
		wr(`PCRC_A_CON1, 16'h0028);
		rchk(`PCRC_A_CON1, 16'h0068);
		rchk(`PCRC_A_WDATL, 16'h0000);
		rchk(`PCRC_A_CON2, 16'h0707);
		rchk(`PCRC_A_DATL, 16'h0000);
		wr(`PCRC_A_WDATL, 16'h55aa);
		rchk(`PCRC_A_WDATL, 16'h0000);
		// stop in idle holds the engine; manual stop gives no interrupt
		wr(`PCRC_A_CON1, 16'ha020);
		wr(`PCRC_A_CON2, 16'h1f1f);
		wr(`PCRC_A_XORL, 16'h1db7);
		wr(`PCRC_A_XORH, 16'h04c1);
		raw = $random(seed);
		wr(`PCRC_A_DATL, raw[15:0]);
		wr(`PCRC_A_DATH, raw[31:16]);
		cpu_idle <= 1'b1;
		wr(`PCRC_A_CON1, 16'ha030);
		repeat (30) @(posedge core_clk);
		rchk(`PCRC_A_CON1, 16'ha130);
		n = irq_cnt;
		wr(`PCRC_A_CON1, 16'ha020);
		cpu_idle <= 1'b0;
		repeat (25) @(posedge core_clk);
		chk(irq_cnt, n);
		rchk(`PCRC_A_CON1, 16'ha120);
		wr(`PCRC_A_CON1, 16'ha030);
		// freeze the engine in mid-word: the running result must hold still
		repeat (3) @(posedge core_clk);
		cpu_idle <= 1'b1;
		rd(`PCRC_A_WDATL, lo);
		rd(`PCRC_A_WDATH, hi);
		crc = {hi, lo};
		rd(`PCRC_A_WDATL, lo);
		rd(`PCRC_A_WDATH, hi);
		chk({hi, lo}, crc);
		cpu_idle <= 1'b0;
		wait_irq(n);
		crc = step(32'h00000000, raw, 32, 32, 32'h04c11db7, 1'b0);
		rd(`PCRC_A_WDATL, lo);
		rd(`PCRC_A_WDATH, hi);
		chk({hi, lo}, crc);
		conclude();
	end
endmodule
